// ---- core/ssr_regs.svh ----
// constants for the spindle synchronisation reference block
//
// Notes on behaviour
// - lock-mode 00 off, 01 slave, 10 master
// - off mode ignores the shared reference line
// - master drives reference and locks to it
// - master reference follows index, idles low
// - only the falling reference edge is used
// - lock must be reached within ten seconds
// - locked phase held within 20 us
// - failed lock raises unit attention 5C01
// - idle sync change raises unit attention
// - busy sync change returns check condition
// - eight-bit skew lags by value/256 revolution
// - every skew value applied, rounded down to whole cycles
// - role change accepted at any time
`ifndef SSR_REGS_SVH
`define SSR_REGS_SVH

// lock-mode encodings
`define SSR_MODE_OFF 2'h0
`define SSR_MODE_SLAVE 2'h1
`define SSR_MODE_MASTER 2'h2
`define SSR_MODE_CONTROL 2'h3

// clock and timing
`define SSR_CLK_MHZ 100
`define SSR_LOCK_TIME_S 10
`define SSR_LOCK_CYC (`SSR_LOCK_TIME_S * `SSR_CLK_MHZ * 1000000)
`define SSR_PHASE_WIN_US 20
`define SSR_PHASE_WIN_CYC (`SSR_PHASE_WIN_US * `SSR_CLK_MHZ)
`define SSR_REF_PERIOD_US 8300
`define SSR_REF_PERIOD_CYC (`SSR_REF_PERIOD_US * `SSR_CLK_MHZ)
`define SSR_REF_TOL_PERMIL 10
`define SSR_REF_MAX_CYC (`SSR_REF_PERIOD_CYC + `SSR_REF_PERIOD_CYC * `SSR_REF_TOL_PERMIL / 1000)
`define SSR_REF_LOSS_CYC (2 * `SSR_REF_MAX_CYC)
`define SSR_REF_HIGH_US 100
`define SSR_REF_HIGH_CYC (`SSR_REF_HIGH_US * `SSR_CLK_MHZ)
`define SSR_SKEW_DEN_LOG2 8

// sense reporting
`define SSR_ASC_SYNC 16'h5c01
`define SSR_ASC_NOSYNC 16'h5c02
`define SSR_KEY_UNIT_ATTN 4'h6
`define SSR_KEY_RECOVERED 4'h1
`define SSR_KEY_HARDWARE 4'h4

`endif

// ---- core/ssr_pkg.sv ----
// types shared by the spindle synchronisation reference block
package ssr_pkg;

    // lock sequencing states
    typedef enum logic [1:0] {
        SSR_ST_OFF,
        SSR_ST_ACQUIRE,
        SSR_ST_LOCKED,
        SSR_ST_UNLOCKED
    } ssr_state_e;

    // one sense report toward the command interface
    typedef struct packed {
        logic check;
        logic all_init;
        logic [3:0] key;
        logic [15:0] asc;
    } ssr_sense_s;

endpackage

// ---- core/ssr_phase_meter.sv ----
// phase comparison of spindle index against the skewed lock point
`timescale 1ns/10ps
`default_nettype none
`include "ssr_regs.svh"

module ssr_phase_meter
    import ssr_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // events
    input wire logic enable_i,
    input wire logic target_i,
    input wire logic index_i,
    // result
    output logic sample_o,
    output logic good_o,
    output logic [15:0] err_o
);

    localparam logic [15:0] WIN = 16'(`SSR_PHASE_WIN_CYC);

    logic [15:0] since_idx_reg;
    logic [15:0] win_cnt_reg;
    logic armed_reg;
    logic hit_reg;

    // index seen shortly before the lock point counts as early
    wire early_hit = index_i || (since_idx_reg <= WIN);
    wire win_end = armed_reg && (win_cnt_reg == WIN);

    // age of the last index edge, saturating just past the window
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            since_idx_reg <= 16'hffff;
        else if (index_i)
            since_idx_reg <= 16'h0000;
        else if (since_idx_reg <= WIN)
            since_idx_reg <= since_idx_reg + 16'h0001;
    end

    // window of +-20 us around each lock point
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            armed_reg <= 1'b0;
            hit_reg <= 1'b0;
            win_cnt_reg <= 16'h0000;
            err_o <= 16'h0000;
        end
        else if (!enable_i)
        begin
            armed_reg <= 1'b0;
            hit_reg <= 1'b0;
        end
        else if (target_i)
        begin
            armed_reg <= 1'b1;
            win_cnt_reg <= 16'h0000;
            hit_reg <= early_hit;
            err_o <= index_i ? 16'h0000 : since_idx_reg;
        end
        else if (armed_reg)
        begin
            win_cnt_reg <= win_cnt_reg + 16'h0001;
            if (index_i && !hit_reg)
            begin
                hit_reg <= 1'b1;
                err_o <= win_cnt_reg + 16'h0001;
            end
            if (win_end)
                armed_reg <= 1'b0;
        end
    end

    // one verdict per revolution, at the far edge of the window
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            sample_o <= 1'b0;
            good_o <= 1'b0;
        end
        else
        begin
            sample_o <= win_end && enable_i && !target_i;
            if (win_end)
                good_o <= hit_reg;
        end
    end

    chk_good_in_window: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        sample_o && good_o |-> err_o <= WIN + 16'h0001)
        else $error("good phase sample outside window");

endmodule
`default_nettype wire

// ---- core/ssr_spindle_sync.sv ----
// spindle synchronisation: mode, reference, lock and sense reporting
`timescale 1ns/10ps
`default_nettype none
`include "ssr_regs.svh"

module ssr_spindle_sync
    import ssr_pkg::*;
#(
    parameter int unsigned LOCK_CYC = `SSR_LOCK_CYC,
    parameter int unsigned REF_LOSS_CYC = `SSR_REF_LOSS_CYC,
    parameter int unsigned REF_HIGH_CYC = `SSR_REF_HIGH_CYC
)
(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    // configuration from the command interface
    input wire logic [1:0] rotation_lock_mode_i,
    input wire logic [7:0] skew_i,
    // operation status from the command interface
    input wire logic io_active_i,
    input wire logic io_end_i,
    input wire logic io_ok_i,
    // spindle index from the motor controller pin
    input wire logic index_i,
    // shared reference line, two-way
    input wire logic spindle_reference_pulse_i,
    output logic spindle_reference_pulse_o,
    output logic spindle_reference_pulse_oe_o,
    // phase-lock point for the spindle servo
    output logic lock_point_o,
    output logic [15:0] phase_err_o,
    // status and sense reports
    output logic synced_o,
    output logic sense_valid_o,
    output ssr_sense_s sense_o
);

    // active roles; 11b control mode is treated as off
    function automatic logic mode_active(input logic [1:0] m);
        mode_active = (m == `SSR_MODE_SLAVE) || (m == `SSR_MODE_MASTER);
    endfunction

    logic rst_s1_reg;
    logic rst_n;
    logic ref_s1_reg;
    logic ref_s2_reg;
    logic ref_d_reg;
    logic idx_s1_reg;
    logic idx_s2_reg;
    logic idx_d_reg;
    logic [1:0] mode_reg;
    logic [19:0] hi_cnt_reg;
    logic [20:0] since_fall_reg;
    logic [20:0] period_reg;
    logic ref_seen_reg;
    logic [29:0] acq_cnt_reg;
    ssr_state_e state_reg;
    ssr_state_e state_next;
    logic ua_pend_reg;
    logic [15:0] ua_asc_reg;
    logic chk_pend_reg;
    logic [15:0] chk_asc_reg;
    logic sample;
    logic good;

    // reset release through two flops
    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            rst_s1_reg <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_s1_reg <= 1'b1;
            rst_n <= rst_s1_reg;
        end
    end

    // pin synchronisers; the first stage feeds only the second
    always_ff @(posedge sys_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ref_s1_reg <= 1'b0;
            ref_s2_reg <= 1'b0;
            ref_d_reg <= 1'b0;
            idx_s1_reg <= 1'b0;
            idx_s2_reg <= 1'b0;
            idx_d_reg <= 1'b0;
        end
        else
        begin
            ref_s1_reg <= spindle_reference_pulse_i;
            ref_s2_reg <= ref_s1_reg;
            ref_d_reg <= ref_s2_reg;
            idx_s1_reg <= index_i;
            idx_s2_reg <= idx_s1_reg;
            idx_d_reg <= idx_s2_reg;
        end
    end

    // mode decode and edge detection
    wire mode_chg = rotation_lock_mode_i != mode_reg;
    wire active = mode_active(mode_reg);
    wire is_master = mode_reg == `SSR_MODE_MASTER;
    wire idx_rise = idx_s2_reg && !idx_d_reg;
    wire ref_fall = active && ref_d_reg && !ref_s2_reg;
    wire ref_lost = since_fall_reg >= 21'(REF_LOSS_CYC);

    // lagging skew as a fraction of the measured period, rounded down to whole cycles
    wire [28:0] skew_prod = 29'(period_reg) * 29'(skew_i);
    wire [20:0] skew_delay = skew_prod[28:`SSR_SKEW_DEN_LOG2];
    wire target = active && ref_seen_reg && !ref_lost && (since_fall_reg == skew_delay);

    // role is taken over whenever the command interface changes it
    always_ff @(posedge sys_clk_i or negedge rst_n)
    begin
        if (!rst_n)
            mode_reg <= `SSR_MODE_OFF;
        else
            mode_reg <= rotation_lock_mode_i;
    end

    // master pulse: launched by our own index, held high a fixed time
    always_ff @(posedge sys_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hi_cnt_reg <= 20'h00000;
            spindle_reference_pulse_o <= 1'b0;
            spindle_reference_pulse_oe_o <= 1'b0;
        end
        else
        begin
            spindle_reference_pulse_oe_o <= is_master && !mode_chg;
            if (!is_master)
            begin
                hi_cnt_reg <= 20'h00000;
                spindle_reference_pulse_o <= 1'b0;
            end
            else if (idx_rise)
            begin
                hi_cnt_reg <= 20'(REF_HIGH_CYC - 1);
                spindle_reference_pulse_o <= 1'b1;
            end
            else if (hi_cnt_reg != 20'h00000)
                hi_cnt_reg <= hi_cnt_reg - 20'h00001;
            else
                spindle_reference_pulse_o <= 1'b0;
        end
    end

    // period of the line, falling edge to falling edge; a master
    // measures its own pulse read back from the line, like a slave
    always_ff @(posedge sys_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            since_fall_reg <= 21'h000000;
            period_reg <= 21'(`SSR_REF_PERIOD_CYC);
            ref_seen_reg <= 1'b0;
        end
        else if (!active)
        begin
            since_fall_reg <= 21'h000000;
            ref_seen_reg <= 1'b0;
        end
        else if (ref_fall)
        begin
            since_fall_reg <= 21'h000000;
            ref_seen_reg <= 1'b1;
            if (ref_seen_reg && !ref_lost)
                period_reg <= since_fall_reg + 21'h000001;
        end
        else if (!ref_lost)
            since_fall_reg <= since_fall_reg + 21'h000001;
    end

    // phase comparison of our index against the skewed lock point
    ssr_phase_meter u_meter (
        .clk_i(sys_clk_i),
        .rst_n_i(rst_n),
        .enable_i(active),
        .target_i(target),
        .index_i(idx_rise),
        .sample_o(sample),
        .good_o(good),
        .err_o(phase_err_o)
    );

    // lock sequencing
    wire in_lock = sample && good;
    wire out_lock = (sample && !good) || (ref_lost && ref_seen_reg);
    wire acq_timeout = acq_cnt_reg == 30'(LOCK_CYC - 1);

    always_comb
    begin
        state_next = state_reg;
        if (mode_chg)
            state_next = mode_active(rotation_lock_mode_i) ? SSR_ST_ACQUIRE : SSR_ST_OFF;
        else
        begin
            case (state_reg)
                SSR_ST_OFF:
                    if (active)
                        state_next = SSR_ST_ACQUIRE;
                SSR_ST_ACQUIRE:
                    if (in_lock)
                        state_next = SSR_ST_LOCKED;
                    else if (acq_timeout)
                        state_next = SSR_ST_UNLOCKED;
                SSR_ST_LOCKED:
                    if (out_lock)
                        state_next = SSR_ST_UNLOCKED;
                SSR_ST_UNLOCKED:
                    if (in_lock)
                        state_next = SSR_ST_LOCKED;
                default:
                    state_next = SSR_ST_OFF;
            endcase
        end
    end

    // events feeding the sense reports
    wire lock_fail = state_reg == SSR_ST_ACQUIRE && state_next == SSR_ST_UNLOCKED;
    wire sync_gain = state_reg == SSR_ST_UNLOCKED && state_next == SSR_ST_LOCKED;
    wire sync_loss = state_reg == SSR_ST_LOCKED && state_next == SSR_ST_UNLOCKED;
    wire sync_chg = sync_gain || sync_loss;
    wire [15:0] chg_asc = sync_gain ? `SSR_ASC_SYNC : `SSR_ASC_NOSYNC;

    // state and lock timer
    always_ff @(posedge sys_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= SSR_ST_OFF;
            acq_cnt_reg <= 30'h00000000;
            synced_o <= 1'b0;
            lock_point_o <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            acq_cnt_reg <= (state_next == SSR_ST_ACQUIRE && state_reg == SSR_ST_ACQUIRE)
                ? acq_cnt_reg + 30'h00000001 : 30'h00000000;
            synced_o <= state_next == SSR_ST_LOCKED;
            lock_point_o <= target;
        end
    end

    // pending reports; a new event wins over the clear in the same cycle
    wire ua_set = lock_fail || (sync_chg && !io_active_i);
    wire chk_set = sync_chg && io_active_i;
    wire chk_emit = chk_pend_reg && io_end_i;
    wire ua_emit = ua_pend_reg && !chk_emit;

    always_ff @(posedge sys_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ua_pend_reg <= 1'b0;
            ua_asc_reg <= `SSR_ASC_SYNC;
            chk_pend_reg <= 1'b0;
            chk_asc_reg <= `SSR_ASC_SYNC;
        end
        else
        begin
            if (ua_set)
            begin
                ua_pend_reg <= 1'b1;
                ua_asc_reg <= lock_fail ? `SSR_ASC_SYNC : chg_asc;
            end
            else if (ua_emit)
                ua_pend_reg <= 1'b0;
            if (chk_set)
            begin
                chk_pend_reg <= 1'b1;
                chk_asc_reg <= chg_asc;
            end
            else if (chk_emit)
                chk_pend_reg <= 1'b0;
        end
    end

    // one report a cycle; the busy operation's answer goes first
    always_ff @(posedge sys_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sense_valid_o <= 1'b0;
            sense_o <= '0;
        end
        else
        begin
            sense_valid_o <= chk_emit || ua_emit;
            if (chk_emit)
            begin
                sense_o.check <= 1'b1;
                sense_o.all_init <= 1'b0;
                sense_o.key <= io_ok_i ? `SSR_KEY_RECOVERED : `SSR_KEY_HARDWARE;
                sense_o.asc <= chk_asc_reg;
            end
            else if (ua_emit)
            begin
                sense_o.check <= 1'b0;
                sense_o.all_init <= 1'b1;
                sense_o.key <= `SSR_KEY_UNIT_ATTN;
                sense_o.asc <= ua_asc_reg;
            end
        end
    end

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_n);

    chk_off_no_drive: assert property (
        !is_master |=> !spindle_reference_pulse_oe_o)
        else $error("reference driven outside master role");
    chk_off_ignores: assert property (
        mode_reg == `SSR_MODE_OFF |=> !synced_o && !lock_point_o)
        else $error("off mode reacted to reference");
    chk_master_drives: assert property (
        is_master && !mode_chg |=> spindle_reference_pulse_oe_o)
        else $error("master not driving reference");
    chk_ref_from_index: assert property (
        is_master && !mode_chg && idx_rise |=> spindle_reference_pulse_o [*2])
        else $error("master pulse not launched by index");
    chk_fall_restarts: assert property (
        ref_fall |=> since_fall_reg == 21'h000000)
        else $error("lock point not taken from falling edge");
    chk_lock_timer: assert property (
        state_reg == SSR_ST_ACQUIRE |-> acq_cnt_reg < 30'(LOCK_CYC))
        else $error("lock time limit overrun");
    chk_fail_report: assert property (
        lock_fail && !chk_pend_reg |=> ##1 sense_valid_o && sense_o.asc == `SSR_ASC_SYNC
            && sense_o.all_init)
        else $error("lock failure not reported");
    chk_idle_change: assert property (
        sync_chg && !io_active_i && !chk_pend_reg |=> ##1 sense_valid_o
            && sense_o.key == `SSR_KEY_UNIT_ATTN && sense_o.asc == $past(chg_asc, 2))
        else $error("idle sync change not reported");
    chk_busy_change: assert property (
        chk_pend_reg && io_end_i |=> sense_valid_o && sense_o.check
            && sense_o.key == ($past(io_ok_i) ? `SSR_KEY_RECOVERED : `SSR_KEY_HARDWARE))
        else $error("busy sync change answer wrong");
    chk_skew_exact: assert property (
        target |=> lock_point_o && $past(since_fall_reg) == $past(skew_delay))
        else $error("lock point off the skew offset");
    chk_sync_cause: assert property (
        $rose(synced_o) |-> $past(in_lock))
        else $error("synced without a good phase sample");

endmodule
`default_nettype wire

// ---- bench/ssr_ref_partner.sv ----
// far-side model: another drive or the host sourcing the shared reference
`timescale 1ns/10ps
`default_nettype none

module ssr_ref_partner #(
    parameter int unsigned PERIOD = 4400,
    parameter int unsigned HIGH = 40
)
(
    // clock
    input wire logic clk_i,
    // role: high while this party is the one reference source
    input wire logic drive_i,
    // line drive and revolution phase
    output logic ref_o,
    output logic ref_oe_o,
    output logic [15:0] phase_o
);
    initial
    begin
        phase_o = 16'h0000;
        ref_o = 1'b0;
        ref_oe_o = 1'b0;
    end

    // zero jitter, exact period: well inside the supplier tolerances
    always @(negedge clk_i)
    begin
        phase_o <= (phase_o == 16'(PERIOD - 1)) ? 16'h0000 : phase_o + 16'h0001;
        ref_oe_o <= drive_i;
        // low, high at revolution start, the fall marks the lock position; toggles every cycle while not driving
        ref_o <= drive_i ? (phase_o < 16'(HIGH)) : ~ref_o;
    end
endmodule

`default_nettype wire

// ---- bench/testbench.sv ----
// self-checking bench for the spindle synchronisation block
`timescale 1ns/10ps
`default_nettype none
`include "ssr_regs.svh"

module testbench;
    import ssr_pkg::*;
    // short counts so the run stays small
    localparam int P = 4400;
    localparam int H = 40;
    localparam int MIS = 2200;
    localparam int LOCK = 8000;
    localparam int LOSS = 6000;
    localparam int HIGHC = 50;
    localparam int CEIL = 95000;
    logic sys_clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [1:0] mode = `SSR_MODE_OFF;
    logic [7:0] skew = 8'h00;
    logic io_act = 1'b0;
    logic io_end = 1'b0;
    logic io_ok = 1'b0;
    logic index_r = 1'b0;
    logic drive = 1'b1;
    logic line;
    logic line_q = 1'b0;
    logic p_ref, p_oe, ref_o, ref_oe, lock_pt, synced, sv;
    logic [15:0] phase, perr;
    ssr_sense_s sense;
    ssr_sense_s exp_q[$];
    int lp_q[$];
    int fail_count = 0;
    int tests_run = 0;
    int cyc = 0;
    int off = 0;
    int lp_mode = 0;
    int dly, dt, n;
    bit ign = 1'b0;
    integer seed = 32'hbc48f88a;
    integer rnd;

    initial
        forever #5 sys_clk_i = ~sys_clk_i;

    // terminated line rests low when nobody drives it
    assign line = ref_oe ? ref_o : (p_oe ? p_ref : 1'b0);

    ssr_ref_partner #(.PERIOD(P), .HIGH(H)) u_ssr_ref_partner (
        .clk_i(sys_clk_i), .drive_i(drive), .ref_o(p_ref), .ref_oe_o(p_oe), .phase_o(phase)
    );

    ssr_spindle_sync #(.LOCK_CYC(LOCK), .REF_LOSS_CYC(LOSS), .REF_HIGH_CYC(HIGHC))
        u_ssr_spindle_sync (
        .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
        .rotation_lock_mode_i(mode), .skew_i(skew),
        .io_active_i(io_act), .io_end_i(io_end), .io_ok_i(io_ok),
        .index_i(index_r), .spindle_reference_pulse_i(line),
        .spindle_reference_pulse_o(ref_o), .spindle_reference_pulse_oe_o(ref_oe),
        .lock_point_o(lock_pt), .phase_err_o(perr),
        .synced_o(synced), .sense_valid_o(sv), .sense_o(sense)
    );

    // index follows the skewed position, plus a chosen phase error
    always @(negedge sys_clk_i)
    begin
        dly = (P * int'(skew)) / 256 + H + off;
        index_r <= ((int'(phase) + 2 * P - dly) % P) < 8;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        tests_run++;
        if (seen !== want)
        begin
            fail_count++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, want);
        end
    endtask

    task automatic close_out();
        if (fail_count == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic ticks(input int k);
        repeat (k) @(negedge sys_clk_i);
    endtask

    // bounded waits; the callers judge the outcome
    task automatic wait_q(input int k);
        int i;
        i = 0;
        while (exp_q.size() != 0 && i < k)
        begin
            ticks(1);
            i++;
        end
    endtask

    task automatic wait_sync(input logic v, input int k);
        int i;
        i = 0;
        while (synced !== v && i < k)
        begin
            ticks(1);
            i++;
        end
    endtask

    function automatic ssr_sense_s mk(input logic c, input logic a, input logic [3:0] k,
        input logic [15:0] q);
        return {c, a, k, q};
    endfunction

    // watcher: lock point timing and sense reports against the notes
    always @(posedge sys_clk_i)
    begin
        cyc <= cyc + 1;
        line_q <= line;
        if (line_q && !line && lp_mode == 1)
            lp_q.push_back(cyc + 4 + (P * int'(skew)) / 256);
        if (lock_pt === 1'b1 && lp_mode == 2)
            check(lock_pt, 1'b0);
        else if (lock_pt === 1'b1 && lp_q.size() > 0)
        begin
            dt = cyc - lp_q.pop_front();
            check(dt inside {[-2:2]}, 1'b1);
        end
        if (sv === 1'b1 && !ign)
        begin
            if (exp_q.size() == 0)
                check(sense, 32'h0);
            else
                check(sense, exp_q.pop_front());
        end
    end

    // ceiling on run length: a hang counts as a failure
    initial
    begin
        repeat (CEIL) @(posedge sys_clk_i);
        fail_count++;
        close_out();
    end

    initial
    begin
        repeat (10) @(negedge sys_clk_i);
        reset_n_i = 1'b1;
        ticks(3);
        // off and unsupported modes ignore a live reference
        lp_mode = 2;
        ticks(P);
        mode = `SSR_MODE_CONTROL;
        ticks(P);
        check({synced, ref_oe}, 2'h0);
        lp_mode = 0;
        // slave, index out of window: acquisition runs out of time
        off = MIS;
        mode = `SSR_MODE_SLAVE;
        exp_q.push_back(mk(1'b0, 1'b1, `SSR_KEY_UNIT_ATTN, `SSR_ASC_SYNC));
        wait_q(LOCK + 3 * P);
        check(exp_q.size(), 0);
        check(synced, 1'b0);
        // index brought into the window: gain reported while idle
        off = 0;
        exp_q.push_back(mk(1'b0, 1'b1, `SSR_KEY_UNIT_ATTN, `SSR_ASC_SYNC));
        wait_q(3 * P);
        check(exp_q.size(), 0);
        check({synced, perr < 16'h0040}, 2'h3);
        // loss during an operation, completed then not completed
        for (int k = 0; k < 2; k++)
        begin
            io_act = 1'b1;
            off = MIS;
            exp_q.push_back(mk(1'b1, 1'b0, k ? `SSR_KEY_HARDWARE : `SSR_KEY_RECOVERED,
                `SSR_ASC_NOSYNC));
            wait_sync(1'b0, 2 * P);
            ticks(20);
            check({synced, perr > 16'h07d0}, 2'h1);
            check(exp_q.size(), 1);
            io_ok = (k == 0);
            io_end = 1'b1;
            ticks(1);
            io_end = 1'b0;
            io_act = 1'b0;
            wait_q(10);
            check(exp_q.size(), 0);
            off = 0;
            exp_q.push_back(mk(1'b0, 1'b1, `SSR_KEY_UNIT_ATTN, `SSR_ASC_SYNC));
            wait_q(3 * P);
            check(exp_q.size(), 0);
        end
        // skew sweep: top value and a random one, lock point within two cycles
        ign = 1'b1;
        rnd = $random(seed);
        for (int k = 0; k < 2; k++)
        begin
            skew = k ? (8'(rnd) | 8'h01) : 8'hff;
            // the lock point takes a new skew at once; a short settle will do
            ticks(16);
            lp_mode = 1;
            ticks(P);
            lp_mode = 0;
            ticks(P);
            check(lp_q.size(), 0);
        end
        skew = 8'h00;
        ticks(2 * P);
        wait_sync(1'b1, 3 * P);
        ticks(8);
        ign = 1'b0;
        // reference vanishes while idle: loss reported
        drive = 1'b0;
        exp_q.push_back(mk(1'b0, 1'b1, `SSR_KEY_UNIT_ATTN, `SSR_ASC_NOSYNC));
        wait_q(LOSS + 2 * P);
        check({exp_q.size() == 0, synced}, 2'h2);
        // role change to master: drives the line and locks to itself
        ign = 1'b1;
        mode = `SSR_MODE_MASTER;
        ticks(3);
        check({ref_oe, p_oe}, 2'h2);
        n = 0;
        while (ref_o !== 1'b1 && n < 2 * P)
        begin
            ticks(1);
            n++;
        end
        n = 0;
        while (ref_o === 1'b1 && n < 4 * HIGHC)
        begin
            ticks(1);
            n++;
        end
        check(n, HIGHC);
        wait_sync(1'b1, 4 * P);
        check(synced, 1'b1);
        mode = `SSR_MODE_OFF;
        ticks(3);
        check(ref_oe, 1'b0);
        close_out();
    end
endmodule

`default_nettype wire
